// *** verilog/lcd_col_consts.svh ***
`ifndef LCD_COL_CONSTS_SVH
`define LCD_COL_CONSTS_SVH

// Panel geometry
`define COL_COUNT        480
`define LANE_COUNT       6
`define DOT_BITS         6
`define GROUP_COUNT      80

// Register offsets (byte addresses)
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_COL_SEL      8'h08
`define REG_COL_DATA     8'h0c

// Control fields and reset values
`define CTRL_ACCEPT_BIT  0
`define CTRL_RESET       1'b1

// Status fields
`define ST_FILL_BIT      0
`define ST_DIR_BIT       1
`define ST_POL_BIT       2
`define ST_BIAS_BIT      3
`define ST_PEND_BIT      4
`define ST_GRP_LSB       8
`define ST_LINE_LSB      16

// Column readback fields
`define CD_UPPER_BIT     8

`endif

// *** verilog/lcd_col_pkg.sv ***
package lcd_col_pkg;

    // Fill sequencer, Gray coded along idle -> fill -> cascade
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_FILL    = 2'b01,
        ST_CASCADE = 2'b11
    } fill_state_t;

    // Controller-side pins after synchronisation
    typedef struct packed {
        logic [35:0] lanes;
        logic        strobe;
        logic        right_start;
        logic        left_start;
        logic        shift_right;
        logic        polarity;
        logic        low_bias;
    } pin_bundle_t;

endpackage

// *** verilog/pin_sync2.sv ***
`timescale 1ns/1ps
`include "lcd_col_consts.svh"

module pin_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // pin_sync2

// *** verilog/lcd_column_data_latch.sv ***
// Functional notes
// - Each clock carries one 36-bit word: six 6-bit lanes, two RGB pixels.
// - Shift right: lane zero to five fill ascending columns, lane zero lowest.
// - Shift left keeps the same lane-to-column order inside each group.
// - Polarity low: odd columns upper range, even lower; high swaps them.
// - All column outputs take the latched row at strobe falling edge.
// - A high strobe is sampled on a rising clock edge.
// - A strobe too close to an edge is taken on the following edge.
// - Row latch transfer completes one clock after the strobe is sampled.
// - Low-bias select high or open gives reduced bias; low gives normal.
`timescale 1ns/1ps
`include "lcd_col_consts.svh"

module lcd_column_data_latch
    import lcd_col_pkg::*;
#(
    parameter int COLS   = `COL_COUNT,
    parameter int LANES  = `LANE_COUNT,
    parameter int DOTW   = `DOT_BITS,
    parameter int GROUPS = `GROUP_COUNT
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Pixel stream from the timing controller
    input  wire logic [LANES*DOTW-1:0] pixel_lanes,
    input  wire logic                 line_strobe,
    input  wire logic                 shift_right,
    input  wire logic                 polarity,
    input  wire logic                 low_bias_select,
    // Cascade start pins, two-way
    input  wire logic                 right_chain_start_pulse_i,
    output logic                      right_chain_start_pulse_o,
    output logic                      right_chain_start_pulse_oe_n,
    input  wire logic                 left_chain_start_pulse_i,
    output logic                      left_chain_start_pulse_o,
    output logic                      left_chain_start_pulse_oe_n,
    // Column outputs to the DAC stage
    output logic [COLS*DOTW-1:0]      column_outputs,
    output logic [COLS-1:0]           column_upper_half,
    output logic                      bias_reduced
);

    pin_bundle_t       pins;
    fill_state_t       state_q;
    fill_state_t       state_d;
    logic [DOTW-1:0]   fill_buf [COLS];
    logic [DOTW-1:0]   row_latch [COLS];
    logic [6:0]        grp_q;
    logic              dir_q;
    logic              strobe_prev_q;
    logic              start_prev_q;
    logic              latch_pend_q;
    logic              pol_row_q;
    logic              accept_q;
    logic [8:0]        col_sel_q;
    logic [15:0]       line_cnt_q;
    logic              start_in;
    logic              start_seen;
    logic [8:0]        base;
    logic              apb_done;
    logic [1:0]        warm_q;

    pin_sync2 #(
        .WIDTH ($bits(pin_bundle_t))
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({pixel_lanes, line_strobe, right_chain_start_pulse_i,
                    left_chain_start_pulse_i, shift_right, polarity,
                    low_bias_select}),
        .sync_out (pins)
    );

    // Synchroniser shows reset zeros for two clocks after release
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            warm_q <= '0;
        end else begin
            warm_q <= {warm_q[0], 1'b1};
        end
    end

    // Start pin chosen by direction; only the first high clock counts
    assign start_in   = pins.shift_right ? pins.right_start : pins.left_start;
    assign start_seen = start_in && !start_prev_q && accept_q;

    // Group base column: right fills upward, left fills downward
    function automatic logic [8:0] group_base(input logic [6:0] grp,
                                              input logic       right);
        logic [6:0] g;
        g = right ? grp : 7'(GROUPS - 1) - grp;
        return 9'(g * LANES);
    endfunction

    assign base = group_base(grp_q, dir_q);

    // Fill sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:    if (start_seen) state_d = ST_FILL;
            ST_FILL:    if (grp_q == 7'(GROUPS - 1)) state_d = ST_CASCADE;
            ST_CASCADE: state_d = ST_IDLE;
            default:    state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q      <= ST_IDLE;
            start_prev_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            start_prev_q <= start_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            grp_q <= '0;
            dir_q <= 1'b1;
        end else if (state_q == ST_IDLE) begin
            grp_q <= '0;
            dir_q <= pins.shift_right;
        end else if (state_q == ST_FILL) begin
            grp_q <= grp_q + 7'd1;
        end
    end

    // Lane k lands on column base+k in either direction
    always_ff @(posedge core_clk) begin
        if (state_q == ST_FILL) begin
            for (int k = 0; k < LANES; k++) begin
                fill_buf[base + 9'(k)] <= pins.lanes[k*DOTW +: DOTW];
            end
        end
    end

    // Cascade pulse leaves on the pin opposite the input
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            right_chain_start_pulse_o    <= 1'b0;
            left_chain_start_pulse_o     <= 1'b0;
            right_chain_start_pulse_oe_n <= 1'b1;
            left_chain_start_pulse_oe_n  <= 1'b1;
        end else begin
            // Direction waits for real pin samples: no drive glitch at release
            if (warm_q[1]) begin
                right_chain_start_pulse_oe_n <= pins.shift_right;
                left_chain_start_pulse_oe_n  <= !pins.shift_right;
            end
            right_chain_start_pulse_o    <= (state_q == ST_CASCADE) && !dir_q;
            left_chain_start_pulse_o     <= (state_q == ST_CASCADE) && dir_q;
        end
    end

    // Strobe: sampled on edge, latch one clock later, outputs on fall
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strobe_prev_q <= 1'b0;
            latch_pend_q  <= 1'b0;
        end else begin
            strobe_prev_q <= pins.strobe;
            latch_pend_q  <= pins.strobe && !strobe_prev_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (latch_pend_q) begin
            for (int c = 0; c < COLS; c++) begin
                row_latch[c] <= fill_buf[c];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            column_outputs    <= '0;
            column_upper_half <= '0;
            pol_row_q         <= 1'b0;
            line_cnt_q        <= '0;
        end else if (!pins.strobe && strobe_prev_q) begin
            for (int c = 0; c < COLS; c++) begin
                column_outputs[c*DOTW +: DOTW] <= row_latch[c];
                // Column index 0 is odd column one
                column_upper_half[c] <= (c % 2 == 0) ^ pins.polarity;
            end
            pol_row_q  <= pins.polarity;
            line_cnt_q <= line_cnt_q + 16'd1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bias_reduced <= 1'b1;
        end else if (warm_q[1]) begin
            bias_reduced <= pins.low_bias;
        end
    end

    // APB: one wait state, effect at the edge where pready is high
    assign apb_done = psel && penable && pready;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
            prdata  <= '0;
            unique case (paddr)
                `REG_CTRL:     prdata[`CTRL_ACCEPT_BIT] <= accept_q;
                `REG_STATUS: begin
                    prdata[`ST_FILL_BIT]               <= state_q != ST_IDLE;
                    prdata[`ST_DIR_BIT]                <= pins.shift_right;
                    prdata[`ST_POL_BIT]                <= pol_row_q;
                    prdata[`ST_BIAS_BIT]               <= bias_reduced;
                    prdata[`ST_PEND_BIT]               <= latch_pend_q;
                    prdata[`ST_GRP_LSB +: 7]           <= grp_q;
                    prdata[`ST_LINE_LSB +: 16]         <= line_cnt_q;
                end
                `REG_COL_SEL:  prdata[8:0] <= col_sel_q;
                `REG_COL_DATA: begin
                    prdata[DOTW-1:0]     <= column_outputs[col_sel_q*DOTW +: DOTW];
                    prdata[`CD_UPPER_BIT] <= column_upper_half[col_sel_q];
                end
                default:       pslverr <= 1'b1;
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            accept_q  <= `CTRL_RESET;
            col_sel_q <= '0;
        end else if (apb_done && pwrite) begin
            if (paddr == `REG_CTRL) begin
                accept_q <= pwdata[`CTRL_ACCEPT_BIT];
            end
            if (paddr == `REG_COL_SEL) begin
                col_sel_q <= (pwdata[8:0] < 9'(COLS)) ? pwdata[8:0] : 9'(COLS - 1);
            end
        end
    end

endmodule // lcd_column_data_latch

// *** dv/lcd_column_data_latch_chk.sv ***
`timescale 1ns/1ps
module lcd_column_data_latch_chk #(
    parameter int COLS = 480,
    parameter int DOTW = 6
) (
    // Clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    // APB
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Pixel side
    input wire logic                  line_strobe,
    input wire logic                  shift_right,
    input wire logic                  low_bias_select,
    input wire logic                  bias_reduced,
    // Cascade pins
    input wire logic                  right_chain_start_pulse_i,
    input wire logic                  right_chain_start_pulse_o,
    input wire logic                  right_chain_start_pulse_oe_n,
    input wire logic                  left_chain_start_pulse_i,
    input wire logic                  left_chain_start_pulse_o,
    input wire logic                  left_chain_start_pulse_oe_n,
    // Columns
    input wire logic [COLS*DOTW-1:0]  column_outputs,
    input wire logic [COLS-1:0]       column_upper_half
);
    logic       acc_q;
    logic [6:0] stb_q;
    wire logic  st_in = shift_right ? right_chain_start_pulse_i : left_chain_start_pulse_i;
    wire logic  cs_out = shift_right ? left_chain_start_pulse_o : right_chain_start_pulse_o;
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            acc_q <= 1'h1;
        else if (psel && penable && pready && pwrite && paddr == 8'h00)
            acc_q <= pwdata[0];
    end
    // Recent strobe samples
    always_ff @(posedge core_clk)
        stb_q <= {stb_q[5:0], line_strobe};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("apb error data");
    bias_hi_a: assert property (low_bias_select [*5] |-> bias_reduced)
        else $error("bias not reduced");
    bias_lo_a: assert property (!low_bias_select [*5] |-> !bias_reduced)
        else $error("bias not normal");
    dir_oe_a: assert property ($stable(shift_right) [*5] |->
        left_chain_start_pulse_oe_n == !shift_right && right_chain_start_pulse_oe_n == shift_right)
        else $error("start pin direction");
    casc_time_a: assert property ($rose(st_in) && acc_q |-> ##[83:85] $rose(cs_out))
        else $error("cascade timing");
    casc_width_a: assert property ($rose(cs_out) |=> !cs_out)
        else $error("cascade width");
    cols_fall_a: assert property (!$stable(column_outputs) |->
        !line_strobe && |stb_q[6:2])
        else $error("columns moved off strobe fall");
    half_pat_a: assert property (column_upper_half inside
        {{COLS{1'b0}}, {COLS/2{2'h1}}, {COLS/2{2'h2}}})
        else $error("polarity pattern");
endmodule // lcd_column_data_latch_chk

bind lcd_column_data_latch lcd_column_data_latch_chk #(.COLS(COLS), .DOTW(DOTW)) u_chk (.*);

// *** dv/tcon_model.sv ***
`timescale 1ns/1ps
module tcon_model (
    // Clock
    input  wire logic core_clk,
    // Stream to the driver
    output logic [35:0] pixel_lanes,
    output logic        line_strobe,
    output logic        right_start,
    output logic        left_start
);
    initial begin
        pixel_lanes = 36'h0;
        line_strobe = 1'h0;
        right_start = 1'h0;
        left_start = 1'h0;
    end
    task automatic send_line(input logic dir, input logic [5:0] base);
        @(posedge core_clk);
        right_start <= dir;
        left_start <= !dir;
        for (int g = 0; g < 80; g++) begin
            @(posedge core_clk);
            right_start <= 1'h0;
            left_start <= 1'h0;
            for (int k = 0; k < 6; k++)
                pixel_lanes[6*k +: 6] <= base + 6'(6 * g + k);
        end
        @(posedge core_clk);
        // Lanes no longer valid
        pixel_lanes <= ~pixel_lanes;
        repeat (6) @(posedge core_clk);
        line_strobe <= 1'h1;
        repeat (2) @(posedge core_clk);
        line_strobe <= 1'h0;
        repeat (4) @(posedge core_clk);
    endtask
endmodule // tcon_model

// *** dv/lcd_column_data_latch_tb.sv ***
`timescale 1ns/1ps
module lcd_column_data_latch_tb;
    logic core_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic shift_right = 1'h1, polarity = 1'h0, low_bias_select = 1'h1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, mr, ml, bias_reduced, line_strobe;
    logic right_chain_start_pulse_o, right_chain_start_pulse_oe_n;
    logic left_chain_start_pulse_o, left_chain_start_pulse_oe_n;
    logic [35:0] pixel_lanes;
    logic [2879:0] column_outputs;
    logic [479:0] column_upper_half;
    wire logic rp = !right_chain_start_pulse_oe_n ? right_chain_start_pulse_o : mr;
    wire logic lp = !left_chain_start_pulse_oe_n ? left_chain_start_pulse_o : ml;
    int errors = 0, n_tests = 0, cyc = 0;
    // Rows: shift, polarity, low bias, data base
    logic [8:0] rows [4] = '{9'h140, 9'h005, 9'h1aa, 9'h0ff};
    lcd_column_data_latch u_dut (.*, .right_chain_start_pulse_i(rp),
        .left_chain_start_pulse_i(lp));
    tcon_model u_tcon (.core_clk(core_clk), .pixel_lanes(pixel_lanes),
        .line_strobe(line_strobe), .right_start(mr), .left_start(ml));
    always #2.5 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        @(posedge core_clk);
        while (pready !== 1'h1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic check_row(input logic dir, input logic pol, input logic [5:0] base);
        int g;
        logic [5:0] v;
        logic u;
        for (int c = 0; c < 480; c++) begin
            g = dir ? c / 6 : 79 - c / 6;
            v = base + 6'(6 * g + c % 6);
            u = ~c[0] ^ pol;
            chk(32'(column_outputs[6*c +: 6]), 32'(v));
            chk(32'(column_upper_half[c]), 32'(u));
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            {shift_right, polarity, low_bias_select} <= rows[i][8:6];
            repeat (8) @(posedge core_clk);
            u_tcon.send_line(rows[i][8], rows[i][5:0]);
            repeat (4) @(posedge core_clk);
            check_row(rows[i][8], rows[i][7], rows[i][5:0]);
            chk(32'(bias_reduced), 32'(rows[i][6]));
            chk(32'({right_chain_start_pulse_oe_n, left_chain_start_pulse_oe_n}),
                32'({rows[i][8], ~rows[i][8]}));
            apb(1'h0, 8'h04, 32'h0);
            chk(rd & 32'hffff001f, {16'(i + 1), 12'h0, rows[i][6], rows[i][7],
                rows[i][8], 1'h0});
            $display("row %0d done", i);
        end
        // Start refused: row must stay as before
        apb(1'h1, 8'h00, 32'h0);
        u_tcon.send_line(1'h0, 6'h11);
        repeat (4) @(posedge core_clk);
        check_row(1'h0, 1'h1, 6'h3f);
        // Accept stays cleared, so the reset test below sees its reset value
        apb(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'h1, 8'h08, 32'h1ff);
        apb(1'h0, 8'h08, 32'h0);
        chk(rd, 32'h1df);
        apb(1'h0, 8'h0c, 32'h0);
        chk(rd, 32'h104);
        $display("refusal and readback done");
        rst_n <= 1'h0;
        repeat (4) @(posedge core_clk);
        chk(32'({|column_outputs, bias_reduced, right_chain_start_pulse_oe_n,
            left_chain_start_pulse_oe_n}), 32'h7);
        rst_n <= 1'h1;
        // Cleared synchronisers must not reach bias or pin direction
        @(posedge core_clk);
        repeat (2) begin
            @(posedge core_clk);
            chk(32'({bias_reduced, right_chain_start_pulse_oe_n,
                left_chain_start_pulse_oe_n}), 32'h7);
        end
        apb(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h1);
        $display("reset test done");
        tally_and_finish();
    end
endmodule // lcd_column_data_latch_tb
